// [hdl/timer_q_pkg.sv]
// shared constants, types and register map of the timer q unit
package timer_q_pkg;

    // bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int CH_N = 4;
    localparam int PRE_W = 7;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IOC0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IOC1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IOC2 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_CCR0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CCR1 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CCR2 = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CCR3 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_CNT = 8'h20;

    // reset values
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] IOC_RST = 8'h00;
    localparam logic [CNT_W-1:0] CCR_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_IDLE = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_READ_IDLE = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;

    // io_control_2 field positions
    localparam int IOC2_EXT_BIT = 2;
    localparam int IOC2_CAP_LSB = 4;

    // timer_control_0 layout: enable, four fixed zeros, clock select
    typedef struct packed {
        logic run;
        logic [3:0] fixed;
        logic [2:0] cks;
    } ctl_s;

    // valid edge choice of one timer input
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_e;

endpackage : timer_q_pkg

// [hdl/edge_detect.sv]
// valid edge detector for one timer input pin
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [1:0] sel,
    input wire logic din,
    output logic hit
);

    logic prev_r; // input level one cycle ago
    timer_q_pkg::edge_sel_e sel_e; // decoded edge choice

    // remember the previous level of the pin
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= din;
        end
    end

    // pick rising, falling, both or no edge
    always_comb begin
        sel_e = timer_q_pkg::edge_sel_e'(sel);
        case (sel_e)
            timer_q_pkg::EDGE_RISE: hit = run & din & ~prev_r;
            timer_q_pkg::EDGE_FALL: hit = run & ~din & prev_r;
            timer_q_pkg::EDGE_BOTH: hit = run & (din ^ prev_r);
            default: hit = 1'b0; // no edge is valid
        endcase
    end

endmodule : edge_detect
`default_nettype wire

// [hdl/timer_q_unit.sv]
// timer q unit: counter, compare buffers, edges, outputs, apb registers
`timescale 1ns/1ps
`default_nettype none
module timer_q_unit #(
    parameter int CH_N = timer_q_pkg::CH_N
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_q_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_q_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [timer_q_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CH_N-1:0] timer_input,
    output logic [CH_N-1:0] timer_output,
    output logic [CH_N-1:0] match_irq
);

    localparam int CW = timer_q_pkg::CNT_W;
    localparam int PW = timer_q_pkg::PRE_W;

    // timing in short: a bus write lands at the edge that ends its access
    // cycle; the counter moves at the edge after a tick; a match is seen
    // in the cycle after the counter takes the buffer value, and both the
    // request and the output toggle come from flip-flops one edge later.
    // stopping is a clear inside the clock, not a reset of the flops, so
    // a request already launched at the stopping edge still stands for
    // its one cycle

    // software visible registers
    timer_q_pkg::ctl_s ctl_r; // timer_control_0
    logic [7:0] ioc0_r; // io_control_0: output enable and level
    logic [7:0] ioc1_r; // io_control_1: input edge selects
    logic [7:0] ioc2_r; // io_control_2: event edge, source, modes
    logic [CW-1:0] ccr_r [CH_N]; // cap_cmp_reg_0 .. cap_cmp_reg_3

    // hidden state
    // the compare buffers sit beside the registers and have no address
    logic [CW-1:0] buf_r [CH_N]; // compare buffers, no bus path
    logic [CW-1:0] cnt_r; // 16-bit counter
    logic [PW-1:0] pre_r; // prescaler of the peripheral clock
    logic step_r; // counter moved in the previous cycle
    logic [CH_N-1:0] out_r; // timer output pins
    logic [CH_N-1:0] irq_r; // match interrupt pulses

    // bus side state
    // all three stand for one access cycle only
    logic [timer_q_pkg::DATA_W-1:0] rdata_r; // read data for access
    logic pready_r; // answer of the access phase
    logic slverr_r; // unmapped address flag

    // combinational helpers
    logic run; // timer enabled
    logic tick; // one count of the counter this cycle
    logic ev_hit; // valid edge on the event input
    logic [CH_N-1:0] cin_hit; // valid edges on capture inputs
    logic [CH_N-1:0] cap_mode; // channel used for capture
    logic [CH_N-1:0] match; // counter equals a buffer
    logic wr_acc; // write taken at this edge
    logic [timer_q_pkg::DATA_W-1:0] rd_mux; // read value
    logic rd_ok; // address is mapped
    logic ctl_wr; // byte write to timer_control_0
    logic ioc_wr; // byte write by lane 0 to any address; the case picks the register
    timer_q_pkg::ctl_s ctl_wd; // written byte seen as control fields

    // internal tick for a clock select code, divider of 2^cks
    // code 0 ticks every cycle, code 7 once in 128 cycles
    function automatic logic int_tick(input logic [PW-1:0] pre,
                                      input logic [2:0] cks);
        logic [PW-1:0] mask;
        mask = PW'((8'h01 << cks) - 8'h01);
        return (pre & mask) == mask;
    endfunction : int_tick

    // merge low two byte lanes of a write into a 16-bit value
    // a lane left out keeps the old byte
    function automatic logic [CW-1:0] lane16(input logic [CW-1:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
        logic [CW-1:0] v;
        v = old;
        if (st[0]) begin
            v[7:0] = wd[7:0];
        end
        if (st[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction : lane16

    // byte offset of a channel's capture/compare register
    // channels above three share the last offset
    function automatic logic [timer_q_pkg::ADDR_W-1:0] ccr_off(
        input int k);
        case (k)
            0: return timer_q_pkg::OFF_CCR0;
            1: return timer_q_pkg::OFF_CCR1;
            2: return timer_q_pkg::OFF_CCR2;
            default: return timer_q_pkg::OFF_CCR3;
        endcase
    endfunction : ccr_off

    // decoded enable, capture use and write strobes
    assign run = ctl_r.run;
    assign cap_mode = ioc2_r[timer_q_pkg::IOC2_CAP_LSB +: CH_N];
    assign wr_acc = psel & penable & pwrite & pready_r;
    // byte-wide registers take lane 0; without it a write is ignored
    assign ctl_wr = wr_acc & pstrb[0] & (paddr == timer_q_pkg::OFF_CTL0);
    assign ioc_wr = wr_acc & pstrb[0];
    assign ctl_wd = pwdata[7:0];

    // valid edge detectors of the capture inputs
    // one detector per input; they only fire while the timer runs
    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : g_cin
            edge_detect u_edge (
                .mclk(mclk),
                .arst_n(arst_n),
                .run(run),
                .sel(ioc1_r[2*g +: 2]),
                .din(timer_input[g]),
                .hit(cin_hit[g])
            );
        end
    endgenerate

    // event input shares pin 0 with its own edge choice
    // a second detector, so capture and counting may pick other edges
    edge_detect u_event (
        .mclk(mclk),
        .arst_n(arst_n),
        .run(run),
        .sel(ioc2_r[1:0]),
        .din(timer_input[0]),
        .hit(ev_hit)
    );

    // count clock selector: external events or divided clock
    // only one source feeds the counter at a time
    always_comb begin
        if (ioc2_r[timer_q_pkg::IOC2_EXT_BIT]) begin
            tick = run & ev_hit;
        end else begin
            tick = run & int_tick(pre_r, ctl_r.cks);
        end
    end

    // prescaler runs only while enabled, cleared when stopped
    // so each start sees a whole first period of the count clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= '0;
        end else if (!run) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + timer_q_pkg::PRE_ONE;
        end
    end

    // 16-bit counter, all ones while stopped
    // the first tick after a start takes it from all ones to zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= timer_q_pkg::CNT_IDLE;
        end else if (!run) begin
            cnt_r <= timer_q_pkg::CNT_IDLE;
        end else if (tick) begin
            cnt_r <= cnt_r + timer_q_pkg::CNT_ONE;
        end
    end

    // marks the cycle in which the counter holds a fresh value
    // without it a counter resting on the buffer value under a slow
    // count clock would hold the match request for many cycles
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            step_r <= 1'b0;
        end else begin
            step_r <= tick;
        end
    end

    // control register 0: whole byte by lane 0, fixed bits kept zero
    // a rewrite of the same value leaves every field as it was, so the
    // prescaler and counter run on undisturbed
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_r <= timer_q_pkg::ctl_s'(timer_q_pkg::CTL0_RST);
        end else if (ctl_wr) begin
            ctl_r.run <= ctl_wd.run;
            ctl_r.fixed <= '0;
            ctl_r.cks <= ctl_wd.cks;
        end
    end

    // io control registers, one byte each
    // pins, edge choices and channel use all change only here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ioc0_r <= timer_q_pkg::IOC_RST;
            ioc1_r <= timer_q_pkg::IOC_RST;
            ioc2_r <= timer_q_pkg::IOC_RST;
        end else if (ioc_wr) begin
            case (paddr)
                timer_q_pkg::OFF_IOC0: ioc0_r <= pwdata[7:0];
                timer_q_pkg::OFF_IOC1: ioc1_r <= pwdata[7:0];
                timer_q_pkg::OFF_IOC2: ioc2_r <= pwdata[7:0];
                default: ioc0_r <= ioc0_r; // other addresses
            endcase
        end
    end

    // per channel: register, hidden buffer, match, output, irq
    // channel k uses bits 2k and 2k+1 of io_control_0
    generate
        for (g = 0; g < CH_N; g++) begin : g_ch
            logic ccr_wr; // write to this channel's register
            assign ccr_wr = wr_acc && paddr == ccr_off(g);

            // capture/compare register: bus write wins over capture
            // both byte lanes are written separately
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    ccr_r[g] <= timer_q_pkg::CCR_RST;
                end else if (ccr_wr) begin
                    ccr_r[g] <= lane16(ccr_r[g], pwdata, pstrb);
                end else if (cap_mode[g] && cin_hit[g]) begin
                    ccr_r[g] <= cnt_r; // capture on a valid edge
                end
            end

            // hidden buffer loaded only from a compare-use write
            // a write in capture use leaves the buffer as it was
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    buf_r[g] <= timer_q_pkg::CCR_RST;
                end else if (ccr_wr && !cap_mode[g]) begin
                    buf_r[g] <= lane16(ccr_r[g], pwdata, pstrb);
                end
            end

            // fresh counter value equal to the buffer
            // the buffer is not compared while the channel captures
            assign match[g] = run & step_r & ~cap_mode[g]
                              & (cnt_r == buf_r[g]);

            // one-cycle match interrupt request
            // stands one cycle, since a match lasts one cycle
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    irq_r[g] <= 1'b0;
                end else begin
                    irq_r[g] <= match[g];
                end
            end

            // output pin: idle level when stopped, toggles on match
            // with the enable bit clear the pin shows the level bit,
            // so software may park it high or low
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    out_r[g] <= 1'b0;
                end else if (!run || !ioc0_r[2*g]) begin
                    out_r[g] <= ioc0_r[2*g+1];
                end else if (match[g]) begin
                    out_r[g] <= ~out_r[g];
                end
            end
        end
    endgenerate

    // read decode; buffers never appear on the bus
    // unmapped addresses read zero and raise the error flag
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        case (paddr)
            timer_q_pkg::OFF_CTL0: rd_mux[7:0] = ctl_r;
            timer_q_pkg::OFF_IOC0: rd_mux[7:0] = ioc0_r;
            timer_q_pkg::OFF_IOC1: rd_mux[7:0] = ioc1_r;
            timer_q_pkg::OFF_IOC2: rd_mux[7:0] = ioc2_r;
            timer_q_pkg::OFF_CCR0: rd_mux[CW-1:0] = ccr_r[0];
            timer_q_pkg::OFF_CCR1: rd_mux[CW-1:0] = ccr_r[1];
            timer_q_pkg::OFF_CCR2: rd_mux[CW-1:0] = ccr_r[2];
            timer_q_pkg::OFF_CCR3: rd_mux[CW-1:0] = ccr_r[3];
            timer_q_pkg::OFF_CNT: begin
                // stopped counter reads as zero though it holds ones
                rd_mux[CW-1:0] = run ? cnt_r
                                     : timer_q_pkg::CNT_READ_IDLE;
            end
            default: rd_ok = 1'b0; // unmapped address
        endcase
    end

    // apb answer: ready in every access phase, no wait states
    // the answer is prepared at the setup edge, so read data shows
    // the register as it stood at that edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready_r <= 1'b0;
            slverr_r <= 1'b0;
            rdata_r <= '0;
        end else if (psel && !penable) begin
            // setup cycle: prepare the answer for the access phase
            pready_r <= 1'b1;
            slverr_r <= ~rd_ok;
            rdata_r <= pwrite ? '0 : rd_mux;
        end else begin
            // answer lasts one access cycle only
            pready_r <= 1'b0;
            slverr_r <= 1'b0;
            rdata_r <= '0;
        end
    end

    // outputs straight from flip-flops
    // nothing combinational reaches a pin
    assign prdata = rdata_r;
    assign pready = pready_r;
    assign pslverr = slverr_r;
    assign timer_output = out_r;
    assign match_irq = irq_r;

endmodule : timer_q_unit
`default_nettype wire

// [testbench/timer_q_monitor.sv]
// port checker of the timer q unit
`timescale 1ns/1ps
`default_nettype none
module timer_q_monitor #(
    parameter int CH_N = 4
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CH_N-1:0] timer_input,
    input wire logic [CH_N-1:0] timer_output,
    input wire logic [CH_N-1:0] match_irq
);
    logic run_r; // enable bit as last written
    // follow completed writes to control register 0
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && pstrb[0]
                     && paddr == timer_q_pkg::OFF_CTL0) begin
            run_r <= pwdata[7];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    unmapped_err_a: assert property (pready && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    rdata_idle_a: assert property (!pready |-> prdata == '0)
        else $error("read data outside access");
    fixed_zero_a: assert property (pready && !pwrite
        && paddr == timer_q_pkg::OFF_CTL0 |-> prdata[6:3] == 4'h0)
        else $error("control bits 6 to 3 not zero");
    idle_count_a: assert property (pready && !pwrite && !run_r
        && paddr == timer_q_pkg::OFF_CNT |-> prdata == '0)
        else $error("stopped counter not read as zero");
    irq_pulse_a: assert property (match_irq[0] |=> !match_irq[0])
        else $error("match request longer than one cycle");
    stop_quiet_a: assert property (!run_r [*3] |-> match_irq == '0)
        else $error("match request while stopped");
endmodule : timer_q_monitor
bind timer_q_unit timer_q_monitor #(.CH_N(CH_N)) timer_q_monitor_inst (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input(timer_input), .timer_output(timer_output),
    .match_irq(match_irq));
`default_nettype wire

// [testbench/pin_model.sv]
// model of the external timer pins: event pulses on input 0
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic mclk,
    input wire logic [3:0] timer_output,
    output logic [3:0] timer_input
);
    // pins idle low
    initial timer_input = 4'h0;
    // one pulse on input 0, slow enough for the sampler
    task automatic pulse;
        @(posedge mclk);
        timer_input[0] <= 1'b1;
        repeat (5) @(posedge mclk);
        timer_input[0] <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask : pulse
endmodule : pin_model
`default_nettype wire

// [testbench/timer_q_unit_tb.sv]
// self-checking bench of the timer q unit
`timescale 1ns/1ps
`default_nettype none
module timer_q_unit_tb;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, tin, tout, irq;
    int num_errors, n_tests, n_irq0;
    timer_q_unit timer_q_unit_inst (.mclk(mclk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input(tin), .timer_output(tout),
        .match_irq(irq));
    pin_model pin_model_inst (.mclk(mclk), .timer_output(tout),
        .timer_input(tin));
    // clock and match pulse tally
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (irq[0] === 1'b1) n_irq0++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd
    // count match pulses and the first channel 0 pulse
    task automatic watch(input int n, output int hits, output int first);
        hits = 0;
        first = -1;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            hits += $countones(irq);
            if (irq[0] === 1'b1 && first < 0) first = i;
        end
    endtask : watch
    task automatic t_reset;
        rd(timer_q_pkg::OFF_CTL0, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++) rd(8'h10 + 8'(4 * k), 32'h0, 1'b0);
        rd(timer_q_pkg::OFF_CNT, 32'h0, 1'b0);
        wr(timer_q_pkg::OFF_CTL0, 32'h87);
        rd(timer_q_pkg::OFF_CTL0, 32'h87, 1'b0);
        wr(timer_q_pkg::OFF_CTL0, 32'h0);
        rd(timer_q_pkg::OFF_CNT, 32'h0, 1'b0);
        rd(8'h24, 32'h0, 1'b1);
    endtask : t_reset
    // four channels matched once each, outputs toggle
    task automatic t_match;
        int h, f;
        wr(timer_q_pkg::OFF_IOC0, 32'h55);
        chk({28'h0, tout}, 32'h0);
        for (int k = 0; k < 4; k++) wr(8'h10 + 8'(4 * k), 32'(4 + 2 * k));
        rd(timer_q_pkg::OFF_CCR2, 32'h8, 1'b0);
        wr(timer_q_pkg::OFF_CTL0, 32'h80);
        watch(40, h, f);
        chk(32'(h), 32'h4);
        chk({28'h0, tout}, 32'hf);
        wr(timer_q_pkg::OFF_CTL0, 32'h0);
    endtask : t_match
    // every clock select code, then a same-value rewrite
    task automatic t_cks;
        int h, f, p;
        wr(timer_q_pkg::OFF_CCR0, 32'h1);
        for (int c = 0; c < 8; c++) begin
            p = 1 << c;
            wr(timer_q_pkg::OFF_CTL0, 32'h80 | 32'(c));
            watch(300, h, f);
            chk(32'(f >= 2 * p - 4 && f <= 2 * p + 4), 32'h1);
            wr(timer_q_pkg::OFF_CTL0, 32'h0);
        end
        wr(timer_q_pkg::OFF_CTL0, 32'h87);
        watch(100, h, f);
        chk(32'(h), 32'h0);
        wr(timer_q_pkg::OFF_CTL0, 32'h87);
        watch(200, h, f);
        chk(32'(f >= 148 && f <= 158), 32'h1);
        wr(timer_q_pkg::OFF_CTL0, 32'h0);
    endtask : t_cks
    // external events on input 0 for each edge choice
    task automatic t_ext;
        int need[4] = '{99, 3, 3, 2};
        int base;
        wr(timer_q_pkg::OFF_CCR0, 32'h2);
        for (int s = 0; s < 4; s++) begin
            wr(timer_q_pkg::OFF_IOC2, 32'h4 | 32'(s));
            wr(timer_q_pkg::OFF_CTL0, 32'h80);
            base = n_irq0;
            for (int i = 1; i <= 4; i++) begin
                pin_model_inst.pulse();
                chk(32'(n_irq0 - base), 32'(i >= need[s]));
            end
            wr(timer_q_pkg::OFF_CTL0, 32'h0);
        end
    endtask : t_ext
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end
    // reset, then the scenarios
    initial begin
        num_errors = 0;
        n_tests = 0;
        n_irq0 = 0;
        mclk = 1'b0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_match();
        t_cks();
        t_ext();
        give_verdict();
    end
endmodule : timer_q_unit_tb
`default_nettype wire
